//--- hdl/ism_limp_qual.sv
// qualifies the fail-safe level before limp home mode is entered
`timescale 1ns/1ps
module ism_limp_qual #(
    parameter logic [ism_pkg::LIMP_CNT_W-1:0] QUAL_CYCLES = ism_pkg::LIMP_CNT_W'(ism_pkg::LIMP_QUALIFY_CYCLES)
) (
    input wire logic clk,
    input wire logic rst_n,
    ism_pin_if.qual pif
);
    import ism_pkg::*;

    ism_limp_s st_q;
    ism_limp_s st_d;

    // (RULE_07) continuous high required
    // any low sample restarts the count, so glitches never add up
    always_comb begin
        st_d = st_q;
        if (!pif.fail_safe) begin
            st_d.cnt = '0;
            st_d.active = 1'b0;
        end else if (st_q.cnt < QUAL_CYCLES) begin
            st_d.cnt = st_q.cnt + 1'b1;
        end else begin
            st_d.active = 1'b1;
        end
    end

    // (RULE_08) parameterised terminal count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pif.limp = st_q.active;

endmodule : ism_limp_qual

//--- hdl/ism_pin_if.sv
// synchronised pin levels and limp state shared between the matrix modules
`timescale 1ns/1ps
interface ism_pin_if;
    import ism_pkg::*;
    logic [NUM_CH-1:0] chan_in;
    logic fail_safe;
    logic limp;
    modport sync (output chan_in, output fail_safe);
    modport qual (input fail_safe, output limp);
    modport core (input chan_in, input fail_safe, input limp);
endinterface : ism_pin_if

//--- hdl/ism_pkg.sv
// constants, offsets and state types for the input switch matrix
package ism_pkg;

    localparam int NUM_CH = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LIMP_CNT_W = 16;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CHAN_ON = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_HW_CFG = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IN_STATE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;

    // field positions
    localparam int GATING_BIT = 0;
    localparam int LIMP_STAT_BIT = 4;
    localparam int IRQ_LIMP_BIT = 4;
    localparam int NUM_EVT = 5;

    // reset values
    localparam logic [NUM_CH-1:0] RST_CHAN_ON = 4'h0;
    localparam logic RST_GATING = 1'b0;
    localparam logic [NUM_EVT-1:0] RST_IRQ_MASK = 5'h00;

    // timing: a least time, so the cycle count rounds up
    localparam int CLK_PERIOD_NS = 40;
    localparam int LIMP_QUALIFY_TIME_NS = 10000;
    localparam int LIMP_QUALIFY_CYCLES = (LIMP_QUALIFY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [NUM_CH-1:0] ch_s1;
        logic [NUM_CH-1:0] ch_s2;
        logic fs_s1;
        logic fs_s2;
    } ism_sync_s;

    typedef struct packed {
        logic [LIMP_CNT_W-1:0] cnt;
        logic active;
    } ism_limp_s;

    typedef struct packed {
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] awaddr;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [DATA_W-1:0] rdata;
        logic [NUM_CH-1:0] chan_on_bits;
        logic gating;
        logic [NUM_CH-1:0] pin_flags;
        logic [NUM_EVT-1:0] irq_stat;
        logic [NUM_EVT-1:0] irq_mask;
        logic [NUM_CH-1:0] pins_prev;
        logic limp_prev;
        logic [NUM_CH-1:0] chan_out;
        logic limp_out;
        logic irq;
    } ism_top_s;

endpackage : ism_pkg

//--- hdl/ism_sync.sv
// two-flop synchronisers for the channel-input and fail-safe pins
`timescale 1ns/1ps
module ism_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ism_pkg::NUM_CH-1:0] chan_raw,
    input wire logic fail_safe_raw,
    ism_pin_if.sync pif
);
    import ism_pkg::*;

    ism_sync_s st_q;
    ism_sync_s st_d;

    // first stage feeds only the second stage
    always_comb begin
        st_d = st_q;
        st_d.ch_s1 = chan_raw;
        st_d.ch_s2 = st_q.ch_s1;
        st_d.fs_s1 = fail_safe_raw;
        st_d.fs_s2 = st_q.fs_s1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pif.chan_in = st_q.ch_s2;
    assign pif.fail_safe = st_q.fs_s2;

endmodule : ism_sync

//--- hdl/ism_top.sv
// input switch matrix: pins and software bits select the channels to switch on
//
// Overview of operation
// (RULE_01) channel-input pins switch channels in sleep, stand-by, ready and limp home.
// (RULE_02) gating select clear: channel on if software bit or pin high.
// (RULE_03) gating select set: channel on only if software bit and pin high.
// (RULE_04) gating select resets to zero, giving the OR combination.
// (RULE_05) limp home forces default combination; only pins switch channels.
// (RULE_06) per-input flag set when pin seen high, cleared by reading status.
// (RULE_07) limp home entered only after fail-safe pin high longer than qualify time.
// (RULE_08) pins synchronised; qualify time counted against a parameter terminal count.
`timescale 1ns/1ps
module ism_top #(
    parameter logic [ism_pkg::LIMP_CNT_W-1:0] LIMP_QUAL_CYCLES = ism_pkg::LIMP_CNT_W'(ism_pkg::LIMP_QUALIFY_CYCLES)
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic [ism_pkg::NUM_CH-1:0] CHANNEL_INPUT_PIN,
    input wire logic FAIL_SAFE_PIN,
    output logic [ism_pkg::NUM_CH-1:0] CHANNEL_ON,
    output logic LIMP_ACTIVE,
    output logic IRQ,
    input wire logic [ism_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [ism_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ism_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [ism_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    import ism_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // pin conditioning

    ism_pin_if pins ();

    // (RULE_08) two-flop pin synchronisers
    ism_sync u_sync (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .chan_raw(CHANNEL_INPUT_PIN),
        .fail_safe_raw(FAIL_SAFE_PIN),
        .pif(pins.sync)
    );

    // (RULE_07) fail-safe qualification
    ism_limp_qual #(
        .QUAL_CYCLES(LIMP_QUAL_CYCLES)
    ) u_limp (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .pif(pins.qual)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // address decode shared by the read and write paths
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a == OFS_CHAN_ON) || (a == OFS_HW_CFG) || (a == OFS_IN_STATE) ||
                      (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
    endfunction : addr_mapped

    // channel combination matrix
    function automatic logic [NUM_CH-1:0] switch_matrix(
        input logic [NUM_CH-1:0] sw_bits,
        input logic [NUM_CH-1:0] pin_lvl,
        input logic gate_and,
        input logic limp
    );
        logic [NUM_CH-1:0] r;
        r = '0;
        if (limp) begin
            // (RULE_05) limp: pins only
            r = pin_lvl;
        end else if (gate_and) begin
            // (RULE_03) AND gating of pin
            r = sw_bits & pin_lvl;
        end else begin
            // (RULE_02) OR of bit and pin
            r = sw_bits | pin_lvl;
        end
        switch_matrix = r;
    endfunction : switch_matrix

    ////////////////////////////////////////////////////////////////////////////////
    // state

    ism_top_s st_q;
    ism_top_s st_d;

    logic aw_take;
    logic w_take;
    logic do_write;
    logic ar_take;
    logic rd_clears_flags;
    logic [NUM_CH-1:0] pin_rise;
    logic limp_rise;
    logic [NUM_EVT-1:0] evt;
    logic [NUM_EVT-1:0] w1c;
    logic [NUM_CH-1:0] flag_clear;

    always_comb begin
        st_d = st_q;
        aw_take = S_AXI_AWVALID && st_q.awready;
        w_take = S_AXI_WVALID && st_q.wready;
        ar_take = S_AXI_ARVALID && st_q.arready;
        w1c = '0;
        flag_clear = '0;
        rd_clears_flags = 1'b0;

        ////////////////////////////////////////////////////////////////////////
        // write channels: address and data may arrive in either order
        if (aw_take) begin
            st_d.aw_held = 1'b1;
            st_d.awaddr = S_AXI_AWADDR;
        end
        if (w_take) begin
            st_d.w_held = 1'b1;
            st_d.wdata = S_AXI_WDATA;
            st_d.wstrb = S_AXI_WSTRB;
        end
        do_write = st_d.aw_held && st_d.w_held && !st_q.bvalid;

        if (do_write) begin
            st_d.aw_held = 1'b0;
            st_d.w_held = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = addr_mapped(st_d.awaddr) ? RESP_OKAY : RESP_SLVERR;
            // all fields live in byte lane 0
            if (st_d.wstrb[0]) begin
                case (st_d.awaddr)
                    OFS_CHAN_ON: begin
                        st_d.chan_on_bits = st_d.wdata[NUM_CH-1:0];
                    end
                    OFS_HW_CFG: begin
                        st_d.gating = st_d.wdata[GATING_BIT];
                    end
                    OFS_IRQ_STAT: begin
                        w1c = st_d.wdata[NUM_EVT-1:0];
                    end
                    OFS_IRQ_MASK: begin
                        st_d.irq_mask = st_d.wdata[NUM_EVT-1:0];
                    end
                    default: begin
                        w1c = '0;
                    end
                endcase
            end
        end else if (st_q.bvalid && S_AXI_BREADY) begin
            st_d.bvalid = 1'b0;
        end
        // only one write in flight; ready drops while a half is held or a response waits
        st_d.awready = !st_d.aw_held && !st_d.bvalid;
        st_d.wready = !st_d.w_held && !st_d.bvalid;

        ////////////////////////////////////////////////////////////////////////
        // read channel
        if (ar_take) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = addr_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            st_d.rdata = '0;
            case (S_AXI_ARADDR)
                OFS_CHAN_ON: begin
                    st_d.rdata[NUM_CH-1:0] = st_q.chan_on_bits;
                end
                OFS_HW_CFG: begin
                    st_d.rdata[GATING_BIT] = st_q.gating;
                end
                OFS_IN_STATE: begin
                    st_d.rdata[NUM_CH-1:0] = st_q.pin_flags;
                    st_d.rdata[LIMP_STAT_BIT] = st_q.limp_out;
                    rd_clears_flags = 1'b1;
                end
                OFS_IRQ_STAT: begin
                    st_d.rdata[NUM_EVT-1:0] = st_q.irq_stat;
                end
                OFS_IRQ_MASK: begin
                    st_d.rdata[NUM_EVT-1:0] = st_q.irq_mask;
                end
                default: begin
                    st_d.rdata = '0;
                end
            endcase
        end else if (st_q.rvalid && S_AXI_RREADY) begin
            st_d.rvalid = 1'b0;
        end
        st_d.arready = !st_d.rvalid;

        ////////////////////////////////////////////////////////////////////////
        // pin status flags
        if (rd_clears_flags) begin
            flag_clear = st_q.pin_flags;
        end
        // (RULE_06) set on high, clear on read
        // a pin still high in the read cycle sets the flag again: set wins
        st_d.pin_flags = (st_q.pin_flags & ~flag_clear) | pins.chan_in;

        ////////////////////////////////////////////////////////////////////////
        // interrupt events: pin rising edges and limp entry
        pin_rise = pins.chan_in & ~st_q.pins_prev;
        limp_rise = pins.limp && !st_q.limp_prev;
        evt = {limp_rise, pin_rise};
        st_d.pins_prev = pins.chan_in;
        st_d.limp_prev = pins.limp;
        st_d.irq_stat = (st_q.irq_stat & ~w1c) | evt;
        st_d.irq = |(st_d.irq_stat & st_d.irq_mask);

        ////////////////////////////////////////////////////////////////////////
        // channel drive
        // (RULE_01) pins act in every mode
        // the stored gating bit survives limp home; only its effect is suppressed
        st_d.chan_out = switch_matrix(st_q.chan_on_bits, pins.chan_in, st_q.gating, pins.limp);
        st_d.limp_out = pins.limp;
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            st_q <= '0;
            // (RULE_04) OR combination after reset
            st_q.gating <= RST_GATING;
            st_q.chan_on_bits <= RST_CHAN_ON;
            st_q.irq_mask <= RST_IRQ_MASK;
            st_q.awready <= 1'b1;
            st_q.wready <= 1'b1;
            st_q.arready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops

    assign CHANNEL_ON = st_q.chan_out;
    assign LIMP_ACTIVE = st_q.limp_out;
    assign IRQ = st_q.irq;
    assign S_AXI_AWREADY = st_q.awready;
    assign S_AXI_WREADY = st_q.wready;
    assign S_AXI_BVALID = st_q.bvalid;
    assign S_AXI_BRESP = st_q.bresp;
    assign S_AXI_ARREADY = st_q.arready;
    assign S_AXI_RVALID = st_q.rvalid;
    assign S_AXI_RRESP = st_q.rresp;
    assign S_AXI_RDATA = st_q.rdata;

endmodule : ism_top

//--- tb/ism_host_model.sv
// host side model: drives the channel-input and fail-safe pin levels
`timescale 1ns/1ps
module ism_host_model (
    input wire logic clk,
    output logic [ism_pkg::NUM_CH-1:0] pins,
    output logic fail_safe
);
    import ism_pkg::*;
    initial begin
        pins = '0;
        fail_safe = 1'b0;
    end
    // pins change just after an edge, like a port write on the host
    task automatic set_pins(input logic [NUM_CH-1:0] v);
        @(posedge clk);
        pins <= v;
    endtask : set_pins
    task automatic set_fs(input logic v);
        @(posedge clk);
        fail_safe <= v;
    endtask : set_fs
endmodule : ism_host_model

//--- tb/ism_top_chk.sv
// port assertions for the input switch matrix
`timescale 1ns/1ps
module ism_top_chk #(
    parameter logic [ism_pkg::LIMP_CNT_W-1:0] LIMP_QUAL_CYCLES = 16'h0008
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic FAIL_SAFE_PIN,
    input wire logic [ism_pkg::NUM_CH-1:0] CHANNEL_ON,
    input wire logic LIMP_ACTIVE,
    input wire logic IRQ,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [ism_pkg::DATA_W-1:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    // length of the present high run of the raw fail-safe pin
    logic [15:0] fs_run_q;
    always_ff @(posedge CLOCK) begin
        if (!RESET_N || !FAIL_SAFE_PIN) begin
            fs_run_q <= '0;
        end else begin
            fs_run_q <= fs_run_q + 16'h0001;
        end
    end
    //////////////////////////////////////////////////////////////
    reset_quiet_a: assert property (@(posedge CLOCK) !RESET_N |=> CHANNEL_ON == '0 && !LIMP_ACTIVE && !IRQ)
        else $error("outputs not quiet after reset");
    limp_early_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        $rose(LIMP_ACTIVE) |-> fs_run_q > LIMP_QUAL_CYCLES) else $error("limp entered too early");
    limp_late_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        fs_run_q > LIMP_QUAL_CYCLES + 6 |-> LIMP_ACTIVE) else $error("limp not entered");
    limp_drop_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !FAIL_SAFE_PIN |-> ##4 !LIMP_ACTIVE) else $error("limp kept after pin low");
    wr_answer_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID) else $error("no write response");
    b_hold_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
    rd_answer_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY) else $error("no read response");
    r_hold_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
endmodule : ism_top_chk
bind ism_top ism_top_chk #(.LIMP_QUAL_CYCLES(LIMP_QUAL_CYCLES)) u_ism_top_chk (
    .CLOCK(CLOCK),
    .RESET_N(RESET_N),
    .FAIL_SAFE_PIN(FAIL_SAFE_PIN),
    .CHANNEL_ON(CHANNEL_ON),
    .LIMP_ACTIVE(LIMP_ACTIVE),
    .IRQ(IRQ),
    .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY)
);

//--- tb/ism_top_tb.sv
// self-checking bench for the input switch matrix
`timescale 1ns/1ps
module ism_top_tb;
    import ism_pkg::*;
    localparam logic [LIMP_CNT_W-1:0] QUAL = 16'h0008;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [NUM_CH-1:0] pins, chan_on;
    logic fs, limp, irq, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int err_total = 0, samples_checked = 0, cyc = 0;
    always #20 clk = ~clk;
    ism_host_model u_ism_host_model (.clk(clk), .pins(pins), .fail_safe(fs));
    ism_top #(.LIMP_QUAL_CYCLES(QUAL)) u_ism_top (.CLOCK(clk), .RESET_N(rst_n), .CHANNEL_INPUT_PIN(pins),
        .FAIL_SAFE_PIN(fs), .CHANNEL_ON(chan_on), .LIMP_ACTIVE(limp), .IRQ(irq), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    //////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    // a hung handshake would otherwise stall the run for ever
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic w8(input int n);
        repeat (n) @(posedge clk);
    endtask : w8
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rd
    //////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(OFS_HW_CFG, d, r);
        chk(d, 32'h0);
        rd(OFS_CHAN_ON, d, r);
        chk({d[29:0], r}, 32'h0);
        chk(chan_on, 4'h0);
    endtask : t_reset
    task automatic t_or();
        wr(OFS_CHAN_ON, 32'h5, r);
        u_ism_host_model.set_pins(4'ha);
        w8(5);
        chk(chan_on, 4'hf);
        u_ism_host_model.set_pins(4'h0);
        w8(5);
        chk(chan_on, 4'h5);
        wr(OFS_CHAN_ON, 32'h0, r);
        u_ism_host_model.set_pins(4'h9);
        w8(5);
        chk(chan_on, 4'h9);
    endtask : t_or
    task automatic t_and();
        wr(OFS_HW_CFG, 32'h1, r);
        wr(OFS_CHAN_ON, 32'h5, r);
        u_ism_host_model.set_pins(4'h6);
        w8(5);
        chk(chan_on, 4'h4);
        // lane 0 disabled: the write must be answered but leave the gating bit alone
        wstrb <= 4'he;
        wr(OFS_HW_CFG, 32'h0, r);
        wstrb <= 4'hf;
        chk(r, RESP_OKAY);
        rd(OFS_HW_CFG, d, r);
        chk(d, 32'h1);
        wr(8'h20, 32'h1, r);
        chk(r, RESP_SLVERR);
        rd(8'h20, d, r);
        chk({d[29:0], r}, 32'h2);
    endtask : t_and
    // answers must stand while the master holds off bready and rready
    task automatic t_stall();
        @(posedge clk);
        awaddr <= OFS_CHAN_ON;
        wdata <= 32'h6;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        w8(3);
        chk(bvalid, 1'b1);
        bready <= 1'b1;
        @(posedge clk);
        chk(bresp, RESP_OKAY);
        bready <= 1'b0;
        araddr <= OFS_CHAN_ON;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        w8(3);
        rready <= 1'b1;
        @(posedge clk);
        chk(rdata, 32'h6);
        rready <= 1'b0;
        wr(OFS_CHAN_ON, 32'h5, r);
        chk(r, RESP_OKAY);
    endtask : t_stall
    task automatic t_flag();
        u_ism_host_model.set_pins(4'h0);
        w8(5);
        rd(OFS_IN_STATE, d, r);
        chk(d, 32'hf);
        rd(OFS_IN_STATE, d, r);
        chk(d, 32'h0);
    endtask : t_flag
    task automatic t_irq();
        chk(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h2, r);
        w8(3);
        chk(irq, 1'b1);
        wr(OFS_IRQ_STAT, 32'h1f, r);
        w8(3);
        chk(irq, 1'b0);
        rd(OFS_IRQ_STAT, d, r);
        chk(d, 32'h0);
    endtask : t_irq
    task automatic t_limp();
        u_ism_host_model.set_fs(1'b1);
        w8(int'(QUAL) - 1);
        u_ism_host_model.set_fs(1'b0);
        w8(10);
        chk(limp, 1'b0);
        u_ism_host_model.set_fs(1'b1);
        w8(int'(QUAL) + 8);
        chk(limp, 1'b1);
        u_ism_host_model.set_pins(4'h3);
        w8(5);
        chk(chan_on, 4'h3);
        rd(OFS_IN_STATE, d, r);
        chk(d[4], 1'b1);
        // pins still high during the read: their flags are set again
        rd(OFS_IN_STATE, d, r);
        chk(d, 32'h13);
        rd(OFS_IRQ_STAT, d, r);
        chk(d, 32'h13);
        u_ism_host_model.set_fs(1'b0);
        w8(5);
        chk(limp, 1'b0);
        chk(chan_on, 4'h1);
    endtask : t_limp
    // reset in mid-run must restore the defaults written over earlier
    task automatic t_rst2();
        rst_n <= 1'b0;
        w8(3);
        rst_n <= 1'b1;
        rd(OFS_HW_CFG, d, r);
        chk(d, 32'h0);
        rd(OFS_IRQ_MASK, d, r);
        chk(d, 32'h0);
        w8(3);
        chk(chan_on, 4'h3);
        chk(irq, 1'b0);
    endtask : t_rst2
    initial begin
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b0;
        arvalid <= 1'b0;
        rready <= 1'b0;
        awaddr <= '0;
        araddr <= '0;
        wdata <= '0;
        wstrb <= 4'hf;
        w8(5);
        rst_n <= 1'b1;
        t_reset();
        t_or();
        t_and();
        t_stall();
        t_flag();
        t_irq();
        t_limp();
        t_rst2();
        close_out();
    end
endmodule : ism_top_tb
